/* pkg/tmr_pkg.sv */
// Purpose: Shared constants and types for the match/capture timer
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: All reset values are zero
package tmr_pkg;
  localparam int ADDR_W = 8;
  localparam int NUM_MATCH = 4;
  localparam int NUM_CAP = 2;
  localparam int NUM_DMA = 2;
  localparam logic [ADDR_W-1:0] REG_STEP = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PSCALE = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PCOUNT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_MCTRL = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_MATCH0 = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_CCTRL = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_CAP0 = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_EXT = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h34;
  localparam logic [ADDR_W-1:0] OFF_MASK = 8'h38;
  localparam logic [ADDR_W-1:0] OFF_DMA = 8'h3C;
  // Control register fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_HOLD = 1;
  localparam int CTRL_MODE = 2;
  // Per-match control: three bits per match
  localparam int MCR_INT = 0;
  localparam int MCR_RST = 1;
  localparam int MCR_STOP = 2;
  localparam int MCR_W = 3;
  // Per-capture control: three bits per channel
  localparam int CCR_RISE = 0;
  localparam int CCR_FALL = 1;
  localparam int CCR_INT = 2;
  localparam int CCR_W = 3;
  // External output register: levels low, actions above
  localparam int EXT_ACT = 4;
  localparam int ACT_W = 2;
  // Status and mask: matches low, captures above
  localparam int ST_CAP = 4;
  localparam int ST_W = 6;
  typedef enum logic [1:0] {
    MODE_TIMER = 2'h0, MODE_RISE = 2'h1, MODE_FALL = 2'h2, MODE_BOTH = 2'h3
  } count_mode_t;
  typedef enum logic [1:0] {
    ACT_NONE = 2'h0, ACT_LOW = 2'h1, ACT_HIGH = 2'h2, ACT_TOGGLE = 2'h3
  } ext_action_t;
endpackage

/* pkg/match_if.sv */
// Purpose: Carries one match channel between controller and comparator
// Assumes: Combinational comparator
// Notes: One instance per match channel
`timescale 1ns/100ps
interface match_if #(parameter int W = 32);
  logic [W-1:0] count;
  logic [W-1:0] value;
  logic tick;
  logic [1:0] action;
  logic level;
  logic hit;
  logic next_level;
  modport ctrl(output count, value, tick, action, level, input hit, next_level);
  modport unit(input count, value, tick, action, level, output hit, next_level);
endinterface

/* rtl/match_unit.sv */
// Purpose: Compares the count with one match value, forms output level
// Assumes: Tick marks the cycle in which the count would advance
// Notes: Purely combinational
`timescale 1ns/100ps
module match_unit (
  // Match channel
  match_if.unit m
);
  always_comb begin
    m.hit = m.tick && (m.count == m.value);
    m.next_level = m.level;
    if (m.hit) begin
      case (m.action)
        tmr_pkg::ACT_LOW: m.next_level = 1'b0;
        tmr_pkg::ACT_HIGH: m.next_level = 1'b1;
        tmr_pkg::ACT_TOGGLE: m.next_level = ~m.level;
        default: m.next_level = m.level;
      endcase
    end
  end
endmodule

/* rtl/edge_sync.sv */
// Purpose: Two-flop synchroniser with edge pulses
// Assumes: Pin is asynchronous to i_clk_sys
// Notes: Edges show two cycles after the pin changes
`timescale 1ns/100ps
module edge_sync (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Pin and edges
  input wire logic i_pin,
  output logic o_rise,
  output logic o_fall
);
  typedef struct packed {
    logic meta;
    logic stable;
    logic last;
  } sync_state_t;
  sync_state_t state;
  sync_state_t next_state;

  always_comb begin
    next_state.meta = i_pin;
    next_state.stable = state.meta;
    next_state.last = state.stable;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      // Chain keeps sampling, so a pin idling high gives no edge after reset
      state <= '{meta: next_state.meta, stable: next_state.stable, last: next_state.stable};
    end else begin
      state <= next_state;
    end
  end

  // Meta flop is read only by the stable flop, and by the last flop in reset
  assign o_rise = state.stable & ~state.last;
  assign o_fall = ~state.stable & state.last;
endmodule

/* rtl/match_capture_timer.sv */
// Purpose: 32-bit timer/counter with prescaler, matches and captures
// Assumes: APB slave, zero wait states, single clock
// Notes: Pins pass two flops before use
//
// Operation
// - Count advances once per prescale period; rate is clock, or count-input edge rate, over prescale plus one.
// - Counts system clocks, or edges of an external count input.
// - Two capture channels copy the count on a selected input edge.
// - A capture with its interrupt enabled sets its interrupt flag.
// - Four match values compared with count; optional interrupt on match.
// - A match set to stop clears the run enable.
// - A match set to reset clears the count to zero.
// - Each match drives an output: low, high, toggle or unchanged.
// - Matches zero and one may raise DMA requests.
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/100ps
module match_capture_timer #(
  parameter int W = 32
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [tmr_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Pins
  input wire logic i_count_pin,
  input wire logic [tmr_pkg::NUM_CAP-1:0] i_capture,
  output logic [tmr_pkg::NUM_MATCH-1:0] o_match_out,
  // DMA and interrupt
  output logic [tmr_pkg::NUM_DMA-1:0] o_dma_req,
  input wire logic [tmr_pkg::NUM_DMA-1:0] i_dma_ack,
  output logic o_irq
);
  localparam int NM = tmr_pkg::NUM_MATCH;
  localparam int NC = tmr_pkg::NUM_CAP;
  localparam int ND = tmr_pkg::NUM_DMA;

  typedef struct packed {
    logic enable;
    logic hold;
    logic [1:0] mode;
    logic [W-1:0] count;
    logic [W-1:0] pscale;
    logic [W-1:0] pcount;
    logic [NM*tmr_pkg::MCR_W-1:0] mcr;
    logic [NM-1:0][W-1:0] mval;
    logic [NC*tmr_pkg::CCR_W-1:0] ccr;
    logic [NC-1:0][W-1:0] cap;
    logic [NM-1:0] ext;
    logic [NM*tmr_pkg::ACT_W-1:0] act;
    logic [tmr_pkg::ST_W-1:0] status;
    logic [tmr_pkg::ST_W-1:0] mask;
    logic [ND-1:0] dma_en;
    logic [ND-1:0] dma_req;
    logic irq;
    logic [31:0] rdata;
  } tmr_state_t;

  tmr_state_t state;
  tmr_state_t next_state;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [NC:0] pins;
  logic [NC:0] pin_rise;
  logic [NC:0] pin_fall;

  assign pins = {i_capture, i_count_pin};

  for (genvar s = 0; s <= NC; s++) begin : g_sync
    edge_sync u_sync (
      .i_clk_sys(i_clk_sys),
      .i_reset(i_reset),
      .i_pin(pins[s]),
      .o_rise(pin_rise[s]),
      .o_fall(pin_fall[s])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count pulse and prescale tick

  logic running;
  logic ext_pulse;
  logic tick;

  assign running = state.enable & ~state.hold;
  // Mode bit 0 selects rising edges, bit 1 falling edges
  assign ext_pulse = (state.mode == tmr_pkg::MODE_TIMER) |
                     (state.mode[0] & pin_rise[0]) | (state.mode[1] & pin_fall[0]);
  // At or above, so lowering the prescale mid-count cannot strand the divider
  assign tick = running & ext_pulse & (state.pcount >= state.pscale);

  ////////////////////////////////////////////////////////////////////////////
  // Match comparators

  logic [NM-1:0] hit;
  logic [NM-1:0] hit_rst;
  logic [NM-1:0] hit_stop;
  logic [NM-1:0] next_ext;

  match_if #(.W(W)) mif [NM] ();

  for (genvar g = 0; g < NM; g++) begin : g_match
    assign mif[g].count = state.count;
    assign mif[g].value = state.mval[g];
    assign mif[g].tick = tick;
    assign mif[g].action = state.act[g*tmr_pkg::ACT_W +: tmr_pkg::ACT_W];
    assign mif[g].level = state.ext[g];
    assign hit[g] = mif[g].hit;
    assign next_ext[g] = mif[g].next_level;
    assign hit_rst[g] = hit[g] & state.mcr[g*tmr_pkg::MCR_W + tmr_pkg::MCR_RST];
    assign hit_stop[g] = hit[g] & state.mcr[g*tmr_pkg::MCR_W + tmr_pkg::MCR_STOP];
    match_unit u_match (
      .m(mif[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture events

  logic [NC-1:0] cap_evt;

  for (genvar c = 0; c < NC; c++) begin : g_cap
    assign cap_evt[c] = (state.ccr[c*tmr_pkg::CCR_W + tmr_pkg::CCR_RISE] & pin_rise[c+1]) |
                        (state.ccr[c*tmr_pkg::CCR_W + tmr_pkg::CCR_FALL] & pin_fall[c+1]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  logic mapped;
  logic bus_wr;
  logic bus_rd;
  logic count_wr;
  logic ctrl_wr;
  logic ext_wr;
  logic status_wr;

  assign mapped = (i_paddr[1:0] == 2'h0) && (i_paddr <= tmr_pkg::OFF_DMA);
  assign bus_wr = i_psel & i_penable & i_pwrite & mapped;
  // Read data is latched in the setup cycle so it comes from a flop
  assign bus_rd = i_psel & ~i_penable & ~i_pwrite;
  assign count_wr = bus_wr && (i_paddr == tmr_pkg::OFF_COUNT);
  assign ctrl_wr = bus_wr && (i_paddr == tmr_pkg::OFF_CTRL);
  assign ext_wr = bus_wr && (i_paddr == tmr_pkg::OFF_EXT);
  assign status_wr = bus_wr && (i_paddr == tmr_pkg::OFF_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_state = state;
    // Counting and match effects
    if (tick) begin
      next_state.pcount = '0;
      next_state.count = state.count + 1'b1;
    end else if (running & ext_pulse) begin
      next_state.pcount = state.pcount + 1'b1;
    end
    if (|hit_rst) begin
      next_state.count = '0;
    end
    if (|hit_stop) begin
      next_state.enable = 1'b0;
    end
    next_state.ext = next_ext;
    if (state.hold) begin
      next_state.count = '0;
      next_state.pcount = '0;
    end
    for (int c = 0; c < NC; c++) begin
      if (cap_evt[c]) begin
        next_state.cap[c] = state.count;
      end
    end
    // Software writes override same-cycle hardware updates other than flag and DMA request sets
    if (bus_wr) begin
      case (i_paddr)
        tmr_pkg::OFF_CTRL: begin
          next_state.enable = i_pwdata[tmr_pkg::CTRL_EN];
          next_state.hold = i_pwdata[tmr_pkg::CTRL_HOLD];
          next_state.mode = i_pwdata[tmr_pkg::CTRL_MODE +: 2];
        end
        tmr_pkg::OFF_COUNT: next_state.count = W'(i_pwdata);
        tmr_pkg::OFF_PSCALE: next_state.pscale = W'(i_pwdata);
        tmr_pkg::OFF_MCTRL: next_state.mcr = i_pwdata[NM*tmr_pkg::MCR_W-1:0];
        tmr_pkg::OFF_CCTRL: next_state.ccr = i_pwdata[NC*tmr_pkg::CCR_W-1:0];
        tmr_pkg::OFF_EXT: begin
          next_state.ext = i_pwdata[NM-1:0];
          next_state.act = i_pwdata[tmr_pkg::EXT_ACT +: NM*tmr_pkg::ACT_W];
        end
        tmr_pkg::OFF_STATUS: next_state.status = state.status & ~i_pwdata[tmr_pkg::ST_W-1:0];
        tmr_pkg::OFF_MASK: next_state.mask = i_pwdata[tmr_pkg::ST_W-1:0];
        tmr_pkg::OFF_DMA: next_state.dma_en = i_pwdata[ND-1:0];
        default: begin
          for (int i = 0; i < NM; i++) begin
            if (i_paddr == tmr_pkg::OFF_MATCH0 + 8'(i) * tmr_pkg::REG_STEP) begin
              next_state.mval[i] = W'(i_pwdata);
            end
          end
        end
      endcase
    end
    // Sticky sets come last so an event beats a same-cycle clear
    for (int i = 0; i < NM; i++) begin
      if (hit[i] && state.mcr[i*tmr_pkg::MCR_W + tmr_pkg::MCR_INT]) begin
        next_state.status[i] = 1'b1;
      end
    end
    for (int c = 0; c < NC; c++) begin
      if (cap_evt[c] && state.ccr[c*tmr_pkg::CCR_W + tmr_pkg::CCR_INT]) begin
        next_state.status[tmr_pkg::ST_CAP + c] = 1'b1;
      end
    end
    for (int d = 0; d < ND; d++) begin
      if (i_dma_ack[d]) begin
        next_state.dma_req[d] = 1'b0;
      end
      if (hit[d] && state.dma_en[d]) begin
        next_state.dma_req[d] = 1'b1;
      end
    end
    next_state.irq = |(next_state.status & next_state.mask);
    // Read data, unmapped addresses read as zero
    next_state.rdata = '0;
    if (bus_rd) begin
      case (i_paddr)
        tmr_pkg::OFF_CTRL: next_state.rdata = 32'({state.mode, state.hold, state.enable});
        tmr_pkg::OFF_COUNT: next_state.rdata = 32'(state.count);
        tmr_pkg::OFF_PSCALE: next_state.rdata = 32'(state.pscale);
        tmr_pkg::OFF_PCOUNT: next_state.rdata = 32'(state.pcount);
        tmr_pkg::OFF_MCTRL: next_state.rdata = 32'(state.mcr);
        tmr_pkg::OFF_CCTRL: next_state.rdata = 32'(state.ccr);
        tmr_pkg::OFF_EXT: next_state.rdata = 32'({state.act, state.ext});
        tmr_pkg::OFF_STATUS: next_state.rdata = 32'(state.status);
        tmr_pkg::OFF_MASK: next_state.rdata = 32'(state.mask);
        tmr_pkg::OFF_DMA: next_state.rdata = 32'(state.dma_en);
        default: begin
          for (int i = 0; i < NM; i++) begin
            if (i_paddr == tmr_pkg::OFF_MATCH0 + 8'(i) * tmr_pkg::REG_STEP) begin
              next_state.rdata = 32'(state.mval[i]);
            end
          end
          for (int c = 0; c < NC; c++) begin
            if (i_paddr == tmr_pkg::OFF_CAP0 + 8'(c) * tmr_pkg::REG_STEP) begin
              next_state.rdata = 32'(state.cap[c]);
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign o_prdata = state.rdata;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~mapped;
  assign o_match_out = state.ext;
  assign o_dma_req = state.dma_req;
  assign o_irq = state.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);

  prescale_wrap_a: assert property (
    tick |=> state.pcount == '0
  ) else $error("Prescale counter did not restart after tick");

  count_step_a: assert property (
    tick && !(|hit_rst) && !count_wr |=> state.count == $past(state.count) + 1'b1
  ) else $error("Count did not advance on tick");

  timer_mode_a: assert property (
    running && state.mode == tmr_pkg::MODE_TIMER && state.pscale == '0 |-> tick
  ) else $error("Timer mode with no prescale missed a tick");

  ext_mode_a: assert property (
    running && state.mode == tmr_pkg::MODE_RISE |-> ext_pulse == pin_rise[0]
  ) else $error("Counter mode pulse not tied to count input edge");

  capture_load_a: assert property (
    cap_evt[0] |=> state.cap[0] == $past(state.count)
  ) else $error("Capture 0 did not load the count");

  capture_irq_a: assert property (
    cap_evt[1] && state.ccr[tmr_pkg::CCR_W + tmr_pkg::CCR_INT] |=> state.status[tmr_pkg::ST_CAP + 1]
  ) else $error("Capture 1 flag not set");

  match_irq_a: assert property (
    hit[0] && state.mcr[tmr_pkg::MCR_INT] |=> state.status[0] && (o_irq || !state.mask[0])
  ) else $error("Match 0 flag or interrupt missing");

  match_stop_a: assert property (
    |hit_stop && !ctrl_wr |=> !state.enable ##1 $stable(state.count)
  ) else $error("Stop on match did not halt counting");

  match_reset_a: assert property (
    |hit_rst && !count_wr |=> state.count == '0
  ) else $error("Reset on match did not clear count");

  ext_toggle_a: assert property (
    hit[0] && state.act[tmr_pkg::ACT_W-1:0] == tmr_pkg::ACT_TOGGLE && !ext_wr
      |=> o_match_out[0] != $past(o_match_out[0])
  ) else $error("Match output 0 did not toggle");

  dma_req_a: assert property (
    hit[1] && state.dma_en[1] |=> o_dma_req[1]
  ) else $error("DMA request 1 not raised on match");

  flag_sticky_a: assert property (
    state.status[0] && !(status_wr && i_pwdata[0]) |=> state.status[0]
  ) else $error("Match 0 flag cleared without software");

  irq_level_a: assert property (
    (state.status & state.mask) != '0 |-> o_irq
  ) else $error("Interrupt low while an enabled flag is set");
endmodule

/* test/tmr_partner.sv */
// Purpose: Far side of the timer: count pin source, capture pins, DMA acknowledge
// Assumes: Bench drives the controls by non-blocking assignment on rising edges
// Notes: Count pin stands still while not running; ack delay models a slow DMA side
`timescale 1ns/100ps
module tmr_partner (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Control from the bench
  input wire logic i_pin_run,
  input wire logic [1:0] i_cap_fire,
  input wire logic [7:0] i_ack_delay,
  // Device side
  input wire logic [1:0] i_dma_req,
  output logic o_count_pin,
  output logic [1:0] o_capture,
  output logic [1:0] o_dma_ack
);
  logic [1:0] div;
  logic [7:0] wait_cnt;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      div <= 2'h0;
      o_count_pin <= 1'b0;
      o_capture <= 2'h0;
      o_dma_ack <= 2'h0;
      wait_cnt <= 8'h00;
    end else begin
      // Slow edges so the two-flop sync never misses one
      if (i_pin_run) begin
        div <= div + 2'h1;
        if (div == 2'h3) begin
          o_count_pin <= ~o_count_pin;
        end
      end
      o_capture <= o_capture ^ i_cap_fire;
      if (o_dma_ack != 2'h0) begin
        o_dma_ack <= 2'h0;
      end else if (i_dma_req != 2'h0) begin
        if (wait_cnt == i_ack_delay) begin
          o_dma_ack <= i_dma_req;
          wait_cnt <= 8'h00;
        end else begin
          wait_cnt <= wait_cnt + 8'h01;
        end
      end else begin
        wait_cnt <= 8'h00;
      end
    end
  end
endmodule

/* test/match_capture_timer_test.sv */
// Purpose: Self-checking bench for the match/capture timer
// Assumes: Zero-wait APB slave, inputs changed just after rising edges
// Notes: Register rows first, then hand-written scenarios, each after a reset
`timescale 1ns/100ps
module match_capture_timer_test;
  typedef struct {
    logic [7:0] a;
    logic [31:0] w;
    logic [31:0] r;
    logic e;
  } row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic count_pin;
  logic [1:0] capture;
  logic [3:0] match_out;
  logic [1:0] dma_req;
  logic [1:0] dma_ack;
  logic irq;
  logic pin_run = 1'b0;
  logic [1:0] cap_fire = 2'h0;
  logic [7:0] ack_delay = 8'h00;
  int fail_count = 0;
  int checked = 0;
  row_t rows [12] = '{
    '{tmr_pkg::OFF_PSCALE, 32'hFFFFFFFF, 32'hFFFFFFFF, 1'b0},
    '{tmr_pkg::OFF_COUNT, 32'h12345678, 32'h12345678, 1'b0},
    '{8'h20, 32'h89ABCDEF, 32'h89ABCDEF, 1'b0},
    '{tmr_pkg::OFF_MCTRL, 32'hFFFFFFFF, 32'h00000FFF, 1'b0},
    '{tmr_pkg::OFF_CCTRL, 32'hFFFFFFFF, 32'h0000003F, 1'b0},
    '{tmr_pkg::OFF_MASK, 32'hFFFFFFFF, 32'h0000003F, 1'b0},
    '{tmr_pkg::OFF_DMA, 32'hFFFFFFFF, 32'h00000003, 1'b0},
    '{tmr_pkg::OFF_PCOUNT, 32'h00000005, 32'h0, 1'b0},
    '{tmr_pkg::OFF_CAP0, 32'h00000005, 32'h0, 1'b0},
    '{tmr_pkg::OFF_STATUS, 32'h0000003F, 32'h0, 1'b0},
    '{8'h40, 32'hFFFFFFFF, 32'h0, 1'b1},
    '{8'h02, 32'hFFFFFFFF, 32'h0, 1'b1}
  };

  ////////////////////////////////////////////////////////////////////////////
  match_capture_timer #(.W(32)) match_capture_timer_inst (
    .i_clk_sys(clk), .i_reset(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_count_pin(count_pin),
    .i_capture(capture), .o_match_out(match_out), .o_dma_req(dma_req),
    .i_dma_ack(dma_ack), .o_irq(irq)
  );
  tmr_partner tmr_partner_inst (
    .i_clk_sys(clk), .i_reset(rst), .i_pin_run(pin_run), .i_cap_fire(cap_fire),
    .i_ack_delay(ack_delay), .i_dma_req(dma_req), .o_count_pin(count_pin),
    .o_capture(capture), .o_dma_ack(dma_ack)
  );

  initial begin
    forever #2.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: bit %h expected %h", $time, got, exp);
    end
  endtask
  // Entered just after a rising edge; leaves one idle edge so psel never flips twice at once
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      $display("Error at %0t: pready %h expected %h", $time, pready, 1'b1);
      fail_count++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic e;
    apb(1'b1, a, d, x, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    logic e;
    apb(1'b0, a, 32'h0, v, e);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk_word(v, exp);
  endtask
  function automatic logic probe(input int s);
    case (s)
      0: return irq;
      1: return dma_req[0];
      default: return match_out[0];
    endcase
  endfunction
  task automatic wait_for(input int s, input logic v, input int lim);
    int n;
    n = 0;
    while (probe(s) !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (probe(s) !== v) begin
      $display("Error at %0t: wait got %h expected %h", $time, probe(s), v);
      fail_count++;
      stop_test();
    end
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask
  // Each fire toggles the pin; sync latency is three cycles, eight leaves margin
  task automatic fire(input int ch);
    cap_fire[ch] <= 1'b1;
    @(posedge clk);
    cap_fire <= 2'h0;
    repeat (8) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] c;
    logic [31:0] v;
    logic e;
    int n;
    do_reset();
    chk_bit(irq, 1'b0);
    chk_bit(pready, 1'b1);
    chk_word({26'h0, match_out, dma_req}, 32'h0);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].w, v, e);
      apb(1'b0, rows[i].a, 32'h0, v, e);
      chk_word(v, rows[i].r);
      chk_bit(e, rows[i].e);
      wr(rows[i].a, 32'h0);
    end
    // Toggle period is (match + 1) * (prescale + 1) with reset on match
    for (int p = 0; p <= 2; p += 2) begin
      do_reset();
      wr(tmr_pkg::OFF_PSCALE, 32'(p));
      wr(tmr_pkg::OFF_MATCH0, 32'h4);
      wr(tmr_pkg::OFF_MCTRL, 32'h3);
      wr(tmr_pkg::OFF_EXT, 32'h30);
      wr(tmr_pkg::OFF_CTRL, 32'h1);
      wait_for(2, 1'b1, 200);
      n = 0;
      while (match_out[0] !== 1'b0 && n < 200) begin
        @(posedge clk);
        n++;
      end
      chk_word(32'(n), 32'(5 * (p + 1)));
    end
    for (int a = 0; a < 4; a++) begin
      do_reset();
      wr(tmr_pkg::OFF_EXT, ((a == 2) ? 32'h0 : 32'h4) | (32'(a) << 8));
      wr(8'h1C, 32'h2);
      wr(tmr_pkg::OFF_MCTRL, 32'h140);
      wr(tmr_pkg::OFF_MASK, 32'h4);
      wr(tmr_pkg::OFF_CTRL, 32'h1);
      wait_for(0, 1'b1, 100);
      chk_bit(match_out[2], (a == 0 || a == 2));
    end
    for (int m = 1; m < 4; m++) begin
      do_reset();
      wr(8'h20, 32'h2);
      wr(tmr_pkg::OFF_MCTRL, 32'hA00);
      wr(tmr_pkg::OFF_MASK, 32'h8);
      wr(tmr_pkg::OFF_CTRL, 32'h1 | (32'(m) << 2));
      repeat (40) @(posedge clk);
      chk_bit(irq, 1'b0);
      pin_run <= 1'b1;
      wait_for(0, 1'b1, 200);
      pin_run <= 1'b0;
    end
    do_reset();
    wr(8'h18, 32'h3);
    wr(tmr_pkg::OFF_MCTRL, 32'h28);
    wr(tmr_pkg::OFF_MASK, 32'h2);
    wr(tmr_pkg::OFF_DMA, 32'h2);
    wr(tmr_pkg::OFF_CTRL, 32'h1);
    wait_for(0, 1'b1, 100);
    chk_bit(dma_req[1], 1'b1);
    rd_chk(tmr_pkg::OFF_CTRL, 32'h0);
    rd(tmr_pkg::OFF_COUNT, c);
    repeat (20) @(posedge clk);
    rd_chk(tmr_pkg::OFF_COUNT, c);
    rd_chk(tmr_pkg::OFF_STATUS, 32'h2);
    wr(tmr_pkg::OFF_MASK, 32'h0);
    wait_for(0, 1'b0, 4);
    wr(tmr_pkg::OFF_MASK, 32'h2);
    wait_for(0, 1'b1, 4);
    wr(tmr_pkg::OFF_STATUS, 32'h2);
    wait_for(0, 1'b0, 4);
    // Counter stopped first so the captured value is known
    do_reset();
    wr(tmr_pkg::OFF_MATCH0, 32'h7);
    wr(tmr_pkg::OFF_MCTRL, 32'h4);
    wr(tmr_pkg::OFF_CCTRL, 32'h2E);
    wr(tmr_pkg::OFF_MASK, 32'h30);
    wr(tmr_pkg::OFF_CTRL, 32'h1);
    repeat (20) @(posedge clk);
    rd(tmr_pkg::OFF_COUNT, c);
    fire(1);
    rd_chk(8'h2C, c);
    wait_for(0, 1'b1, 4);
    fire(0);
    rd_chk(tmr_pkg::OFF_STATUS, 32'h20);
    fire(0);
    rd_chk(tmr_pkg::OFF_STATUS, 32'h30);
    rd_chk(tmr_pkg::OFF_CAP0, c);
    wr(tmr_pkg::OFF_CTRL, 32'h3);
    rd_chk(tmr_pkg::OFF_COUNT, 32'h0);
    do_reset();
    ack_delay <= 8'h06;
    wr(tmr_pkg::OFF_MATCH0, 32'h28);
    wr(tmr_pkg::OFF_MCTRL, 32'h2);
    wr(tmr_pkg::OFF_DMA, 32'h1);
    wr(tmr_pkg::OFF_CTRL, 32'h1);
    wait_for(1, 1'b1, 100);
    chk_bit(dma_req[1], 1'b0);
    repeat (3) @(posedge clk);
    chk_bit(dma_req[0], 1'b1);
    wait_for(1, 1'b0, 20);
    stop_test();
  end
endmodule
